// [design/sspp_port.sv]
// Purpose: Write-only three-wire programming port of a dual synthesizer.
// Assumes: Serial clock at most half the system clock after sampling.
// Notes: Pins are oversampled at 40 MHz; no software registers.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Function
// RQ1 - Each rising serial clock edge shifts the data line into a 24-bit word.
// RQ2 - A rising load strobe copies the word into its selected latch only.
// RQ3 - The host keeps the serial clock at or below 20 MHz.
// RQ4 - The host holds the load strobe low while bits are shifted.
// RQ5 - The host sends each word as three 8-bit bytes; the bench sends one word as four bytes.
// RQ6 - The host raises the load strobe after the third byte.
// RQ7 - The host SPI master uses clock phase zero.
// RQ8 - A chip enable input low forces power-down of both halves.
// RQ9 - Lock detect can be routed to the multiplexed test output.
// RQ10 - The host keeps the integer divide at or above 31 or 91 per prescaler.
// RQ11 - Each half stays powered down until all of its latches were written.
// RQ12 - Extra bits beyond 24 push out the oldest, keeping the newest 24.
module sspp_port
    import sspp_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SERIAL_CLOCK,
    input wire logic SERIAL_INPUT_LINE,
    input wire logic LOAD_STROBE,
    input wire logic CHIP_ENABLE,
    input wire logic LOCK_DETECT,
    output logic MULTIPLEXED_TEST_OUTPUT,
    output logic RF_POWER_DOWN,
    output logic IF_POWER_DOWN,
    output logic [SSPP_NUM_LATCH*SSPP_WORD_W-1:0] LATCH_WORDS,
    output logic [SSPP_NUM_LATCH-1:0] LATCH_WRITE
);

    logic sclk_rise;
    logic serial_input_line_lvl;
    logic le_rise;
    logic ce_lvl;
    logic lock_lvl;

    sspp_sync_edge u_sclk (.clk(CLK), .reset_n(RESET_N), .din(SERIAL_CLOCK),
        .level(), .rise(sclk_rise));
    sspp_sync_edge u_data (.clk(CLK), .reset_n(RESET_N),
        .din(SERIAL_INPUT_LINE), .level(serial_input_line_lvl), .rise());
    sspp_sync_edge u_le (.clk(CLK), .reset_n(RESET_N), .din(LOAD_STROBE),
        .level(), .rise(le_rise));
    sspp_sync_edge u_ce (.clk(CLK), .reset_n(RESET_N), .din(CHIP_ENABLE),
        .level(ce_lvl), .rise());
    sspp_sync_edge u_lock (.clk(CLK), .reset_n(RESET_N), .din(LOCK_DETECT),
        .level(lock_lvl), .rise());

    ////////////////////////////////////////////////////////////////////////////
    // Shift register and bit count

    logic [SSPP_WORD_W-1:0] shift_r;
    logic [SSPP_WORD_W-1:0] shift_nxt;
    logic [SSPP_CNT_W-1:0] cnt_r;
    logic [SSPP_CNT_W-1:0] cnt_nxt;

    always_comb begin
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        if (sclk_rise) begin
            // Oldest bit falls off the top [RQ12]
            shift_nxt = {shift_r[SSPP_WORD_W-2:0], serial_input_line_lvl}; // [RQ1]
            if (cnt_r != SSPP_CNT_MAX) begin
                cnt_nxt = cnt_r + 5'h01;
            end
        end
        if (le_rise) begin
            cnt_nxt = 5'h00;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            shift_r <= SSPP_WORD_RST;
            cnt_r <= 5'h00;
        end else begin
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latches, power state, test output

    function automatic logic [SSPP_NUM_LATCH-1:0] sel_onehot(
        input logic [SSPP_CTL_W-1:0] ctl
    );
        logic [SSPP_NUM_LATCH-1:0] oh;
        oh = '0;
        if (ctl < 3'h7) begin
            oh[ctl] = 1'b1;
        end
        return oh;
    endfunction : sel_onehot

    logic [SSPP_NUM_LATCH*SSPP_WORD_W-1:0] latch_r;
    logic [SSPP_NUM_LATCH*SSPP_WORD_W-1:0] latch_nxt;
    logic [SSPP_NUM_LATCH-1:0] wr_r;
    logic [SSPP_NUM_LATCH-1:0] wr_nxt;
    logic [SSPP_NUM_LATCH-1:0] seen_r;
    logic [SSPP_NUM_LATCH-1:0] seen_nxt;
    logic rf_pd_r;
    logic rf_pd_nxt;
    logic if_pd_r;
    logic if_pd_nxt;
    logic mux_r;
    logic mux_nxt;
    logic [SSPP_NUM_LATCH-1:0] sel;

    assign sel = sel_onehot(shift_r[SSPP_CTL_W-1:0]);

    always_comb begin
        latch_nxt = latch_r;
        wr_nxt = '0;
        seen_nxt = seen_r;
        if (le_rise) begin
            // Unused code 7 is dropped rather than aliasing a latch
            for (int i = 0; i < SSPP_NUM_LATCH; i++) begin
                if (sel[i]) begin
                    latch_nxt[i*SSPP_WORD_W +: SSPP_WORD_W] = shift_r; // [RQ2]
                end
            end
            wr_nxt = sel;
            seen_nxt = seen_r | sel; // [RQ11]
        end
        rf_pd_nxt = !ce_lvl
            || ((seen_r & SSPP_RF_SET) != SSPP_RF_SET); // [RQ8] [RQ11]
        if_pd_nxt = !ce_lvl
            || ((seen_r & SSPP_IF_SET) != SSPP_IF_SET); // [RQ8] [RQ11]
        // Lock select lives in latch 3 (shared), field above control bits
        mux_nxt = (latch_r[3*SSPP_WORD_W+SSPP_MUX_LSB +: SSPP_CTL_W]
            == SSPP_MUX_LOCK) ? lock_lvl : 1'b0; // [RQ9]
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            latch_r <= '0;
            wr_r <= '0;
            seen_r <= SSPP_SEEN_RST;
            rf_pd_r <= 1'b1;
            if_pd_r <= 1'b1;
            mux_r <= 1'b0;
        end else begin
            latch_r <= latch_nxt;
            wr_r <= wr_nxt;
            seen_r <= seen_nxt;
            rf_pd_r <= rf_pd_nxt;
            if_pd_r <= if_pd_nxt;
            mux_r <= mux_nxt;
        end
    end

    assign LATCH_WORDS = latch_r;
    assign LATCH_WRITE = wr_r;
    assign RF_POWER_DOWN = rf_pd_r;
    assign IF_POWER_DOWN = if_pd_r;
    assign MULTIPLEXED_TEST_OUTPUT = mux_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_shift_on_edge: assert property ( // [RQ1]
        @(posedge CLK) disable iff (!RESET_N)
        sclk_rise |=> shift_r[0] == $past(serial_input_line_lvl))
        else $error("shift did not take data bit");
    a_keep_newest: assert property ( // [RQ12]
        @(posedge CLK) disable iff (!RESET_N)
        sclk_rise |=> shift_r[SSPP_WORD_W-1:1]
            == $past(shift_r[SSPP_WORD_W-2:0]))
        else $error("older bits not kept in order");
    // Count of fresh bits since the last strobe, capped at one word
    a_count_clear: assert property ( // [RQ12]
        @(posedge CLK) disable iff (!RESET_N)
        le_rise |=> cnt_r == 5'h00)
        else $error("bit count not cleared by strobe");
    a_count_sat: assert property ( // [RQ12]
        @(posedge CLK) disable iff (!RESET_N)
        (sclk_rise && !le_rise && cnt_r == SSPP_CNT_MAX)
            |=> cnt_r == SSPP_CNT_MAX)
        else $error("bit count passed a full word");
    a_latch_load: assert property ( // [RQ2]
        @(posedge CLK) disable iff (!RESET_N)
        (le_rise && shift_r[2:0] == 3'h2) |=>
            latch_r[2*SSPP_WORD_W +: SSPP_WORD_W] == $past(shift_r))
        else $error("selected latch not loaded");
    a_latch_hold: assert property ( // [RQ2]
        @(posedge CLK) disable iff (!RESET_N)
        (le_rise && shift_r[2:0] != 3'h0) |=>
            $stable(latch_r[SSPP_WORD_W-1:0]))
        else $error("unselected latch changed");
    a_write_onehot: assert property ( // [RQ2]
        @(posedge CLK) disable iff (!RESET_N)
        $onehot0(LATCH_WRITE))
        else $error("more than one latch written");
    a_ce_powerdown: assert property ( // [RQ8]
        @(posedge CLK) disable iff (!RESET_N)
        !ce_lvl |=> RF_POWER_DOWN && IF_POWER_DOWN)
        else $error("chip enable low without power-down");
    a_rf_wakeup: assert property ( // [RQ11]
        @(posedge CLK) disable iff (!RESET_N)
        !RF_POWER_DOWN |-> (seen_r & SSPP_RF_SET) == SSPP_RF_SET)
        else $error("RF half up before its latches written");
    a_if_wakeup: assert property ( // [RQ11]
        @(posedge CLK) disable iff (!RESET_N)
        (ce_lvl && (seen_r & SSPP_IF_SET) == SSPP_IF_SET) |=>
            !IF_POWER_DOWN)
        else $error("IF half stuck in power-down");
    a_lock_route: assert property ( // [RQ9]
        @(posedge CLK) disable iff (!RESET_N)
        (latch_r[3*SSPP_WORD_W+SSPP_MUX_LSB +: SSPP_CTL_W] == SSPP_MUX_LOCK)
            |=> MULTIPLEXED_TEST_OUTPUT == $past(lock_lvl))
        else $error("lock detect not routed");

endmodule : sspp_port

// [shared/sspp_pkg.sv]
// Purpose: Constants for the synthesizer serial programming port.
// Assumes: 40 MHz system clock; serial pins are asynchronous.
// Notes: Latch select uses the low three bits of each word.
package sspp_pkg;

    localparam int SSPP_WORD_W = 24;
    localparam int SSPP_CTL_W = 3;
    localparam int SSPP_NUM_LATCH = 7;
    localparam int SSPP_CNT_W = 5;
    localparam logic [SSPP_CNT_W-1:0] SSPP_CNT_MAX = 5'h18;
    localparam logic [SSPP_WORD_W-1:0] SSPP_WORD_RST = 24'h000000;
    localparam logic [SSPP_NUM_LATCH-1:0] SSPP_SEEN_RST = 7'h00;
    // RF half needs latches 0..3, IF half needs latches 3..6
    localparam logic [SSPP_NUM_LATCH-1:0] SSPP_RF_SET = 7'h0F;
    localparam logic [SSPP_NUM_LATCH-1:0] SSPP_IF_SET = 7'h78;
    localparam int SSPP_CLK_MHZ = 40;
    localparam int SSPP_SCLK_MAX_MHZ = 20;
    // Lock-detect source code on the test output select field
    localparam logic [SSPP_CTL_W-1:0] SSPP_MUX_LOCK = 3'h1;
    localparam int SSPP_MUX_LSB = 3;

    typedef enum logic [1:0] {
        SSPP_EDGE_NONE,
        SSPP_EDGE_RISE,
        SSPP_EDGE_FALL
    } sspp_edge_t;

endpackage : sspp_pkg

// [design/sspp_sync_edge.sv]
// Purpose: Two-stage synchroniser with rising-edge pulse.
// Assumes: Input is asynchronous to CLK.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module sspp_sync_edge
    import sspp_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic din,
    output logic level,
    output logic rise
);

    logic meta_r;
    logic sync_r;
    logic hist_r;
    logic meta_nxt;
    logic sync_nxt;
    logic hist_nxt;

    always_comb begin
        meta_nxt = din;
        sync_nxt = meta_r;
        hist_nxt = sync_r;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            hist_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            hist_r <= hist_nxt;
        end
    end

    assign level = sync_r;
    assign rise = sync_r & ~hist_r;

endmodule : sspp_sync_edge

// [sim/sspp_host.sv]
// Purpose: Host serial master model for the programming port.
// Assumes: Phase-zero master, 4 clocks per serial phase (5 MHz).
// Notes: Strobe is left high after a word until the next one.
`timescale 1ns/1ps
module sspp_host (
    input wire logic clk,
    output logic sclk,
    output logic serial_input_line,
    output logic strobe
);
    initial begin
        sclk = 1'b0;
        serial_input_line = 1'b0;
        strobe = 1'b0;
    end

    // Slow phases keep well under the serial rate limit
    task automatic send(input logic [31:0] w, input int nbytes);
        @(posedge clk);
        #2 strobe = 1'b0;
        for (int i = nbytes * 8 - 1; i >= 0; i--) begin
            repeat (4) @(posedge clk);
            #2 sclk = 1'b0;
            serial_input_line = w[i]; // Stable before the rising edge
            repeat (4) @(posedge clk);
            #2 sclk = 1'b1;
        end
        repeat (4) @(posedge clk);
        #2 sclk = 1'b0;
        // Idle data line must not keep the last bit
        serial_input_line = ~serial_input_line;
        repeat (4) @(posedge clk);
        #2 strobe = 1'b1;
    endtask : send
endmodule : sspp_host

// [sim/tb.sv]
// Purpose: Self-checking bench for the programming port.
// Assumes: Host model drives the three serial pins.
// Notes: Latch words are chosen so bits[2:0] pick the latch.
`timescale 1ns/1ps
module tb;
    import sspp_pkg::*;
    logic clk, reset_n, ce, lock, sclk, serial_input_line, strobe, mux, rf_pd, if_pd;
    logic [SSPP_NUM_LATCH*SSPP_WORD_W-1:0] words, exp_words;
    logic [SSPP_NUM_LATCH-1:0] wr;
    int num_errors = 0;
    int checks_done = 0;

    sspp_port sspp_port_inst (.CLK(clk), .RESET_N(reset_n),
        .SERIAL_CLOCK(sclk), .SERIAL_INPUT_LINE(serial_input_line),
        .LOAD_STROBE(strobe), .CHIP_ENABLE(ce), .LOCK_DETECT(lock),
        .MULTIPLEXED_TEST_OUTPUT(mux), .RF_POWER_DOWN(rf_pd),
        .IF_POWER_DOWN(if_pd), .LATCH_WORDS(words), .LATCH_WRITE(wr));
    sspp_host sspp_host_inst (.clk(clk), .sclk(sclk), .serial_input_line(serial_input_line),
        .strobe(strobe));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [167:0] got, input logic [167:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : wait_clk

    ////////////////////////////////////////////////////////////////////
    // Send a word; code 7 must load nothing, others pulse once
    task automatic load(input logic [31:0] w, input int nbytes);
        int sel;
        sel = int'(w[2:0]);
        sspp_host_inst.send(w, nbytes);
        for (int n = 0; n < 12 && wr === 7'h00; n++) wait_clk(1);
        if (sel != 7 && wr === 7'h00) begin
            // Commit never seen: count it and go to the verdict
            num_errors++;
            finish_test();
        end else begin
            if (sel != 7) begin
                exp_words[sel*24 +: 24] = w[23:0];
                chk(wr, 7'h01 << sel);
            end
            chk(words, exp_words);
            wait_clk(1);
            chk(wr, 7'h00);
        end
    endtask : load

    task automatic ce_case(input logic v, input logic [1:0] exp_pd);
        ce = v;
        wait_clk(6);
        chk({rf_pd, if_pd}, exp_pd);
    endtask : ce_case

    task automatic lock_case(input logic v);
        lock = v;
        wait_clk(6);
        chk(mux, v);
    endtask : lock_case

    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        lock = 1'b0;
        exp_words = '0;
        wait_clk(6);
        reset_n = 1'b1;
        chk(words, exp_words);
        chk({wr, mux, rf_pd, if_pd}, 10'h003);
        // Words never hold an integer below the prescaler minimum
        for (int i = 0; i < 3; i++) load(32'h123450 | i, 3);
        wait_clk(2);
        chk(rf_pd, 1'b1);
        load(32'hABC00B, 3);
        wait_clk(2);
        chk({rf_pd, if_pd}, 2'b01);
        for (int i = 4; i < 7; i++) load(32'h9876A0 | i, 3);
        wait_clk(2);
        chk(if_pd, 1'b0);
        load(32'h5A5A5F, 3);
        load(32'hEE765431, 4);
        lock_case(1'b1);
        lock_case(1'b0);
        ce_case(1'b0, 2'b11);
        ce_case(1'b1, 2'b00);
        load(32'hABC003, 3);
        lock = 1'b1;
        wait_clk(6);
        chk(mux, 1'b0);
        finish_test();
    end
endmodule : tb
